// ---- hdl/hbc_pkg.sv ----
// constants and register map of the half-bridge and high-side control block
`default_nettype none

package hbc_pkg;

	// ======================================================
	// register indices; byte address is four times the index
	localparam logic [7:0] HB_OUT_IDX   = 8'h01;
	localparam logic [7:0] HS_OUT_IDX   = 8'h02;
	localparam logic [7:0] HB_SCTL_IDX  = 8'h08;
	localparam logic [7:0] HS_STAT_IDX  = 8'h09;
	localparam logic [7:0] SYS_CTL_IDX  = 8'h0a;
	localparam logic [7:0] IRQ_FLAG_IDX = 8'h0b;
	localparam logic [7:0] IRQ_MASK_IDX = 8'h0c;
	localparam logic [7:0] AMUX_CTL_IDX = 8'h0d;

	// ======================================================
	// field positions
	localparam int RECIRC_BIT  = 7;
	localparam int HS_PWM_LSB  = 3;
	localparam int PSE_BIT     = 0;
	localparam int HTS_LSB     = 1;
	localparam int VIS_BIT     = 3;
	localparam int LV_BIT      = 0;
	localparam int HV_BIT      = 1;
	localparam int HT_BIT      = 2;
	localparam int HOT_THRESHOLD_IRQ_ENABLE_BIT    = 2;
	localparam int CSA_BIT     = 0;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_ERR  = 2'b10;

	// ======================================================
	// break-before-make dead time
	localparam int CLK_NS   = 8;
	localparam int DEAD_NS  = 100;
	localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;

	// byte address of a register index
	function automatic logic [7:0] reg_addr(input logic [7:0] idx);
		reg_addr = {idx[5:0], 2'b00};
	endfunction : reg_addr

endpackage : hbc_pkg

`default_nettype wire

// ---- hdl/hbc_bridge.sv ----
// one half-bridge: mode decode, trips and break-before-make
`default_nettype none
`timescale 1ns/1ps

module hbc_bridge
	import hbc_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [1:0] sel,       // {high, low} select
	input  wire logic       pwm_in,
	input  wire logic       recirc,
	input  wire logic       enable,
	input  wire logic       high_block,
	input  wire logic       oc_high,
	input  wire logic       oc_low,
	input  wire logic       clr,
	output logic            high_gate,
	output logic            low_gate,
	output logic            oc_event
);

	logic       trip_hi_r;
	logic       trip_lo_r;
	logic [3:0] dead_r;
	logic       hi_req;
	logic       lo_req;
	logic       dead_done;

	// mode decode and trips
	assign hi_req = enable && !high_block && !trip_hi_r && !oc_high &&
		(sel == 2'b10 || (sel == 2'b11 && pwm_in));
	assign lo_req = enable && !trip_lo_r && !oc_low &&
		(sel == 2'b01 || (sel == 2'b11 && recirc && !pwm_in));
	assign dead_done = (dead_r == 4'(DEAD_CYC));
	assign oc_event  = oc_high || oc_low;

	// overcurrent trips, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trip_hi_r <= 1'b0;
			trip_lo_r <= 1'b0;
		end else begin
			trip_hi_r <= oc_high || (trip_hi_r && !clr);
			trip_lo_r <= oc_low || (trip_lo_r && !clr);
		end
	end

	// dead-time counter runs while both FETs are off
	always_ff @(posedge aclk) begin
		if (!aresetn)
			dead_r <= 4'h0;
		else if (high_gate || low_gate)
			dead_r <= 4'h0;
		else if (!dead_done)
			dead_r <= dead_r + 4'h1;
	end

	// gate drive; a FET turns on only after the dead time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_gate <= 1'b0;
			low_gate  <= 1'b0;
		end else begin
			high_gate <= hi_req && (high_gate ||
				(!low_gate && dead_done));
			low_gate  <= lo_req && (low_gate ||
				(!high_gate && dead_done));
		end
	end

endmodule : hbc_bridge

`default_nettype wire

// ---- hdl/hbc_switch.sv ----
// one high-side switch: on, PWM and inrush-limit modes
`default_nettype none
`timescale 1ns/1ps

module hbc_switch
	import hbc_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic on_bit,
	input  wire logic pwm_bit,
	input  wire logic pwm_in,
	input  wire logic enable,
	input  wire logic oc,
	input  wire logic clr,
	output logic      gate,
	output logic      oc_event
);

	logic pwm_d_r;
	logic trip_r;
	logic rise;
	logic trip_eff;

	assign rise     = pwm_in && !pwm_d_r;
	// a PWM rising edge restarts the output in PWM mode
	assign trip_eff = trip_r && !(rise && pwm_bit && !on_bit);
	assign oc_event = oc && enable && (on_bit || pwm_bit);

	// previous PWM level for edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pwm_d_r <= 1'b0;
		else
			pwm_d_r <= pwm_in;
	end

	// trip latch; limit mode never trips, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			trip_r <= 1'b0;
		else
			trip_r <= (oc_event && !(on_bit && pwm_bit)) ||
				(trip_eff && !clr);
	end

	// gate drive per mode
	always_ff @(posedge aclk) begin
		if (!aresetn)
			gate <= 1'b0;
		else if (!enable)
			gate <= 1'b0;
		else case ({pwm_bit, on_bit})
			2'b01:   gate <= !trip_eff && !oc;
			2'b10:   gate <= pwm_in && !trip_eff && !oc;
			2'b11:   gate <= 1'b1;
			default: gate <= 1'b0;
		endcase
	end

endmodule : hbc_switch

`default_nettype wire

// ---- hdl/hbc_top.sv ----
// half-bridge and high-side control with AXI4-Lite registers
`default_nettype none
`timescale 1ns/1ps

module hbc_top
	import hbc_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [7:0] s_axi_awaddr,
	input  wire logic       s_axi_awvalid,
	output logic            s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0] s_axi_wstrb,
	input  wire logic       s_axi_wvalid,
	output logic            s_axi_wready,
	output logic [1:0]      s_axi_bresp,
	output logic            s_axi_bvalid,
	input  wire logic       s_axi_bready,
	input  wire logic [7:0] s_axi_araddr,
	input  wire logic       s_axi_arvalid,
	output logic            s_axi_arready,
	output logic [31:0]     s_axi_rdata,
	output logic [1:0]      s_axi_rresp,
	output logic            s_axi_rvalid,
	input  wire logic       s_axi_rready,
	input  wire logic       pwm_in,
	input  wire logic       temp_first_hit,
	input  wire logic       temp_second_hit,
	input  wire logic       low_supply_hit,
	input  wire logic       high_supply_hit,
	input  wire logic [3:0] bridge_oc_high,
	input  wire logic [3:0] bridge_oc_low,
	input  wire logic [2:0] switch_oc,
	output logic [3:0]      bridge_high_gate,
	output logic [3:0]      bridge_low_gate,
	output logic [2:0]      switch_gate,
	output logic            aux_stage_enable,
	output logic            hot_irq,
	output logic            sense_gain_low
);

	// ======================================================
	// register state
	logic [7:0] hb_out_r;      // half_bridge_output_select
	logic [5:0] hs_out_r;      // {pwm[2:0], on[2:0]}
	logic       recirc_r;      // recirculation_mode
	logic [3:0] bocf_r;        // bridge_overcurrent_flag
	logic [2:0] socf_r;        // side_switch_overcurrent_flag
	logic       pse_r;         // power_stage_enable
	logic [1:0] hts_r;         // hot_shutdown_select
	logic       vis_r;         // voltage_shutdown_select
	logic       lv_r;          // low_supply_flag
	logic       hv_r;          // high_supply_flag
	logic       ht_r;          // hot_threshold_flag
	logic       hot_threshold_irq_enable_r;        // hot_threshold_irq_enable
	logic       csa_r;         // sense_gain_select
	logic [7:0] rd_mux;
	logic [3:0] bocf_set;
	logic [2:0] socf_set;
	logic [3:0] bclr;
	logic [2:0] sclr;
	logic       wr_go;
	logic       ht_kill;
	logic       t2_kill;
	logic       v_kill;
	logic       bridge_en;
	logic       switch_en;

	// ======================================================
	// protection decisions
	assign ht_kill   = ht_r && (hts_r != 2'b00);
	assign t2_kill   = (hts_r == 2'b00) && temp_second_hit;
	assign v_kill    = (lv_r || hv_r) && !vis_r;
	assign bridge_en = pse_r && !v_kill && !t2_kill;
	assign switch_en = pse_r && !v_kill && !t2_kill && !ht_kill;
	assign hot_irq   = ht_r && hot_threshold_irq_enable_r;
	assign sense_gain_low = csa_r;

	// stages outside this block share the stage enable
	always_ff @(posedge aclk) begin
		if (!aresetn)
			aux_stage_enable <= 1'b0;
		else
			aux_stage_enable <= pse_r && !t2_kill;
	end

	// ======================================================
	// AXI4-Lite write channel
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == reg_addr(HB_OUT_IDX))  || (a == reg_addr(HS_OUT_IDX))
		      || (a == reg_addr(HB_SCTL_IDX)) || (a == reg_addr(HS_STAT_IDX))
		      || (a == reg_addr(SYS_CTL_IDX)) || (a == reg_addr(IRQ_FLAG_IDX))
		      || (a == reg_addr(IRQ_MASK_IDX))
		      || (a == reg_addr(AMUX_CTL_IDX));
	endfunction : mapped

	function automatic logic wr_hit(input logic [7:0] idx);
		wr_hit = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == reg_addr(idx));
	endfunction : wr_hit

	// address and data are taken together
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;

	// write response one cycle after the take
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_ERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// plain control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hb_out_r <= REG_RESET;
			hs_out_r <= REG_RESET[5:0];
			recirc_r <= REG_RESET[RECIRC_BIT];
			pse_r    <= REG_RESET[PSE_BIT];
			hts_r    <= REG_RESET[HTS_LSB +: 2];
			vis_r    <= REG_RESET[VIS_BIT];
			hot_threshold_irq_enable_r   <= REG_RESET[HOT_THRESHOLD_IRQ_ENABLE_BIT];
			csa_r    <= REG_RESET[CSA_BIT];
		end else begin
			if (wr_hit(HB_OUT_IDX))
				hb_out_r <= s_axi_wdata[7:0];
			if (wr_hit(HS_OUT_IDX))
				hs_out_r <= s_axi_wdata[5:0];
			if (wr_hit(HB_SCTL_IDX))
				recirc_r <= s_axi_wdata[RECIRC_BIT];
			if (wr_hit(SYS_CTL_IDX)) begin
				pse_r <= s_axi_wdata[PSE_BIT];
				hts_r <= s_axi_wdata[HTS_LSB +: 2];
				vis_r <= s_axi_wdata[VIS_BIT];
			end
			if (wr_hit(IRQ_MASK_IDX))
				hot_threshold_irq_enable_r <= s_axi_wdata[HOT_THRESHOLD_IRQ_ENABLE_BIT];
			if (wr_hit(AMUX_CTL_IDX))
				csa_r <= s_axi_wdata[CSA_BIT];
		end
	end

	// ======================================================
	// write-1-to-clear flags; a new event wins over the clear
	assign bclr = wr_hit(HB_SCTL_IDX) ? s_axi_wdata[3:0] : 4'h0;
	assign sclr = wr_hit(HS_STAT_IDX) ? s_axi_wdata[2:0] : 3'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bocf_r <= REG_RESET[3:0];
			socf_r <= REG_RESET[2:0];
		end else begin
			bocf_r <= bocf_set | (bocf_r & ~bclr);
			socf_r <= socf_set | (socf_r & ~sclr);
		end
	end

	// supply and temperature flags stay while the cause persists
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lv_r <= REG_RESET[LV_BIT];
			hv_r <= REG_RESET[HV_BIT];
			ht_r <= REG_RESET[HT_BIT];
		end else begin
			lv_r <= low_supply_hit || (lv_r &&
				!(wr_hit(IRQ_FLAG_IDX) && s_axi_wdata[LV_BIT]));
			hv_r <= high_supply_hit || (hv_r &&
				!(wr_hit(IRQ_FLAG_IDX) && s_axi_wdata[HV_BIT]));
			ht_r <= temp_first_hit || (ht_r &&
				!(wr_hit(IRQ_FLAG_IDX) && s_axi_wdata[HT_BIT]));
		end
	end

	// ======================================================
	// AXI4-Lite read channel
	always_comb begin
		rd_mux = 8'h00;
		case (s_axi_araddr)
			reg_addr(HB_OUT_IDX):   rd_mux = hb_out_r;
			reg_addr(HS_OUT_IDX):   rd_mux = {2'b00, hs_out_r};
			reg_addr(HB_SCTL_IDX):  rd_mux = {recirc_r, 3'b000, bocf_r};
			reg_addr(HS_STAT_IDX):  rd_mux = {5'h00, socf_r};
			reg_addr(SYS_CTL_IDX):  rd_mux = {4'h0, vis_r, hts_r, pse_r};
			reg_addr(IRQ_FLAG_IDX): rd_mux = {5'h00, ht_r, hv_r, lv_r};
			reg_addr(IRQ_MASK_IDX): rd_mux = {5'h00, hot_threshold_irq_enable_r, 2'b00};
			reg_addr(AMUX_CTL_IDX): rd_mux = {7'h00, csa_r};
			default:                rd_mux = 8'h00;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	// read data registered, one cycle after the take
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_mux};
			s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_ERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ======================================================
	// output stages
	for (genvar i = 0; i < 4; i++) begin : g_bridge
		hbc_bridge u_bridge (
			.aclk       (aclk),
			.aresetn    (aresetn),
			.sel        (hb_out_r[2*i +: 2]),
			.pwm_in     (pwm_in),
			.recirc     (recirc_r),
			.enable     (bridge_en),
			.high_block (ht_kill),
			.oc_high    (bridge_oc_high[i]),
			.oc_low     (bridge_oc_low[i]),
			.clr        (bclr[i]),
			.high_gate  (bridge_high_gate[i]),
			.low_gate   (bridge_low_gate[i]),
			.oc_event   (bocf_set[i])
		);
	end

	for (genvar j = 0; j < 3; j++) begin : g_switch
		hbc_switch u_switch (
			.aclk     (aclk),
			.aresetn  (aresetn),
			.on_bit   (hs_out_r[j]),
			.pwm_bit  (hs_out_r[HS_PWM_LSB + j]),
			.pwm_in   (pwm_in),
			.enable   (switch_en),
			.oc       (switch_oc[j]),
			.clr      (sclr[j]),
			.gate     (switch_gate[j]),
			.oc_event (socf_set[j])
		);
	end

	// ======================================================
	// assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_stage_off;
		!pse_r |=> (bridge_high_gate == 4'h0) && (bridge_low_gate == 4'h0)
			&& (switch_gate == 3'h0);
	endproperty
	a_stage_off: assert property (p_stage_off)
		else $error("gate on without stage enable");

	property p_no_shoot;
		(bridge_high_gate & bridge_low_gate) == 4'h0;
	endproperty
	a_no_shoot: assert property (p_no_shoot)
		else $error("both FETs of a bridge on");

	property p_dead_time;
		$fell(bridge_low_gate[0]) |-> !bridge_high_gate[0] [*8];
	endproperty
	a_dead_time: assert property (p_dead_time)
		else $error("high FET on inside dead time");

	property p_oc_trip;
		bridge_oc_high[0] |=> bocf_r[0] && !bridge_high_gate[0];
	endproperty
	a_oc_trip: assert property (p_oc_trip)
		else $error("bridge overcurrent not handled");

	property p_oc_clear;
		bclr[0] && !bocf_set[0] |=> !bocf_r[0];
	endproperty
	a_oc_clear: assert property (p_oc_clear)
		else $error("bridge flag not cleared by write one");

	property p_volt_off;
		(lv_r || hv_r) && !vis_r |=> (bridge_high_gate == 4'h0)
			&& (bridge_low_gate == 4'h0);
	endproperty
	a_volt_off: assert property (p_volt_off)
		else $error("bridge on during supply fault");

	property p_hot_hold;
		temp_first_hit |=> ht_r;
	endproperty
	a_hot_hold: assert property (p_hot_hold)
		else $error("hot flag lost while still hot");

	property p_hot_irq;
		temp_first_hit && hot_threshold_irq_enable_r |=> hot_irq;
	endproperty
	a_hot_irq: assert property (p_hot_irq)
		else $error("hot interrupt missing");

	property p_pwm_low;
		(hb_out_r[7:6] == 2'b11) && !pwm_in |=> !bridge_high_gate[3];
	endproperty
	a_pwm_low: assert property (p_pwm_low)
		else $error("high FET on with PWM low");

	property p_no_recirc;
		(hb_out_r[7:6] == 2'b11) && !recirc_r |=> !bridge_low_gate[3];
	endproperty
	a_no_recirc: assert property (p_no_recirc)
		else $error("low FET on without recirculation");

	property p_sw_pwm;
		(hs_out_r[1] == 1'b0) && hs_out_r[HS_PWM_LSB + 1] && switch_oc[1]
			|=> !switch_gate[1];
	endproperty
	a_sw_pwm: assert property (p_sw_pwm)
		else $error("switch not tripped in PWM mode");

	c_bridge_trip: cover property (bridge_high_gate[0] ##1 bocf_r[0]);
	c_recirc: cover property (bridge_high_gate[3] ##[1:40] bridge_low_gate[3]);
	c_sw_restart: cover property (socf_r[0] ##[1:40] switch_gate[0]);
	c_write_done: cover property (s_axi_bvalid && s_axi_bready);

endmodule : hbc_top

`default_nettype wire

// ---- tb/hbc_power_model.sv ----
// power stage model: shorted loads draw overcurrent through a conducting FET
`default_nettype none
`timescale 1ns/1ps

module hbc_power_model (
	input  wire logic [3:0] bridge_high_gate,
	input  wire logic [3:0] bridge_low_gate,
	input  wire logic [2:0] switch_gate,
	input  wire logic [3:0] short_high,
	input  wire logic [3:0] short_low,
	input  wire logic [2:0] short_switch,
	output logic      [3:0] bridge_oc_high,
	output logic      [3:0] bridge_oc_low,
	output logic      [2:0] switch_oc
);
	// ==========================================================
	// sense lines: a short shows only while its FET is on
	assign bridge_oc_high = bridge_high_gate & short_high;
	assign bridge_oc_low  = bridge_low_gate & short_low;
	assign switch_oc      = switch_gate & short_switch;
endmodule : hbc_power_model
`default_nettype wire

// ---- tb/hbc_top_tb_top.sv ----
// self-checking bench for the half-bridge and high-side control block
`default_nettype none
`timescale 1ns/1ps

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module hbc_top_tb_top;
	import hbc_pkg::*;
	localparam logic [7:0] A_SEL = {HB_OUT_IDX[5:0], 2'b00};
	localparam logic [7:0] A_SW  = {HS_OUT_IDX[5:0], 2'b00};
	localparam logic [7:0] A_BST = {HB_SCTL_IDX[5:0], 2'b00};
	localparam logic [7:0] A_SST = {HS_STAT_IDX[5:0], 2'b00};
	localparam logic [7:0] A_SYS = {SYS_CTL_IDX[5:0], 2'b00};
	localparam logic [7:0] A_IRQ = {IRQ_FLAG_IDX[5:0], 2'b00};
	localparam logic [7:0] A_MSK = {IRQ_MASK_IDX[5:0], 2'b00};
	localparam logic [7:0] A_MUX = {AMUX_CTL_IDX[5:0], 2'b00};
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pwm;
	logic awready, wready, bvalid, arready, rvalid, aux, irq, gain;
	logic t1, t2, lvh, hvh;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdv;
	logic [1:0] bresp, rresp, rsp;
	logic [3:0] hg, lg, och, ocl, sh, sl;
	logic [2:0] sg, ocs, ss;
	int checks, n_mismatch;

	hbc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_in(pwm),
		.temp_first_hit(t1), .temp_second_hit(t2), .low_supply_hit(lvh),
		.high_supply_hit(hvh), .bridge_oc_high(och), .bridge_oc_low(ocl),
		.switch_oc(ocs), .bridge_high_gate(hg), .bridge_low_gate(lg),
		.switch_gate(sg), .aux_stage_enable(aux), .hot_irq(irq),
		.sense_gain_low(gain));

	hbc_power_model u_pwr (.bridge_high_gate(hg), .bridge_low_gate(lg),
		.switch_gate(sg), .short_high(sh), .short_low(sl),
		.short_switch(ss), .bridge_oc_high(och), .bridge_oc_low(ocl),
		.switch_oc(ocs));

	// ==========================================================
	// clock, 8 ns period
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	task automatic hang();
		n_mismatch++;
		$display("[ERR] handshake wait ran out");
		results();
	endtask : hang

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	// ==========================================================
	// bus master: hold each channel until its handshake edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int i;
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1;
		bready <= 1'b1;
		// each channel is released at its own handshake edge
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awready === 1'b1) aw_ok = 1'b1;
			if (wready === 1'b1) w_ok = 1'b1;
			if (aw_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
			if (aw_ok && w_ok) break;
		end
		if (i == 50) hang();
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (bvalid === 1'b1) break;
		end
		if (i == 50) hang();
		rsp = bresp; bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int i;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready === 1'b1) break;
		end
		if (i == 50) hang();
		arvalid <= 1'b0;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (rvalid === 1'b1) break;
		end
		if (i == 50) hang();
		rdv = rdata; rsp = rresp; rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	// ==========================================================
	// scenarios
	task automatic t_regs();
		rd(A_SEL); `CHK("sel rst", 32'h0, rdv)
		rd(A_BST); `CHK("recirc rst", 32'h0, rdv)
		wr(A_SEL, 8'ha5); `CHK("wr okay", RESP_OKAY, rsp)
		rd(A_SEL); `CHK("sel rw", 32'ha5, rdv)
		rd(8'h3c); `CHK("unmapped", RESP_ERR, rsp)
		wr(8'h3c, 8'h5a); `CHK("wr unmapped", RESP_ERR, rsp)
		wr(A_MUX, 8'h01); `CHK("gain low", 1'b1, gain)
		wr(A_MUX, 8'h00); `CHK("gain high", 1'b0, gain)
		wr(A_SEL, 8'h00);
		$display("test regs done");
	endtask : t_regs

	task automatic t_modes();
		wr(A_SYS, 8'h01); pwm <= 1'b1;
		wr(A_SEL, 8'he4); cyc(16);
		`CHK("hi pwm1", 4'hc, hg) `CHK("lo pwm1", 4'h2, lg)
		pwm <= 1'b0; cyc(16);
		`CHK("hi pwm0", 4'h4, hg) `CHK("lo diode", 4'h2, lg)
		wr(A_BST, 8'h80); cyc(16); `CHK("lo recirc", 4'ha, lg)
		pwm <= 1'b1; cyc(16); `CHK("recirc pwm1", 4'h2, lg)
		wr(A_SYS, 8'h00); cyc(3); `CHK("no pse", 4'h0, hg | lg)
		wr(A_SYS, 8'h01); wr(A_BST, 8'h00); wr(A_SEL, 8'h01); cyc(16);
		wr(A_SEL, 8'h02); `CHK("dead time", 2'b00, {hg[0], lg[0]})
		cyc(16); `CHK("hi after dead", 1'b1, hg[0])
		$display("test modes done");
	endtask : t_modes

	task automatic t_bridge_oc();
		wr(A_SEL, 8'h06); cyc(16); sh <= 4'h1; sl <= 4'h2; cyc(4);
		`CHK("oc off", 2'b00, {hg[0], lg[1]})
		sh <= 4'h0; sl <= 4'h0;
		wr(A_BST, 8'h00); rd(A_BST); `CHK("w0 kept", 32'h3, rdv)
		wr(A_BST, 8'h03); rd(A_BST); `CHK("w1 clr", 32'h0, rdv)
		cyc(16); `CHK("reenable", 2'b11, {hg[0], lg[1]})
		wr(A_SEL, 8'h00);
		$display("test bridge_oc done");
	endtask : t_bridge_oc

	task automatic t_switch();
		wr(A_SW, 8'h11); cyc(3); `CHK("on pwm", 3'b011, sg)
		ss <= 3'b011; cyc(4); ss <= 3'b000; cyc(4);
		`CHK("tripped", 3'b000, sg)
		rd(A_SST); `CHK("sw flags", 32'h3, rdv)
		pwm <= 1'b0; cyc(3); pwm <= 1'b1; cyc(3);
		`CHK("pwm restart", 3'b010, sg)
		wr(A_SST, 8'h03); cyc(3); `CHK("on restart", 3'b011, sg)
		wr(A_SW, 8'h24); cyc(3); ss <= 3'b100; cyc(4);
		`CHK("limit on", 1'b1, sg[2])
		ss <= 3'b000; rd(A_SST); `CHK("limit flag", 32'h4, rdv)
		wr(A_SYS, 8'h00); cyc(3); `CHK("sw no pse", 3'b000, sg)
		wr(A_SST, 8'h07); wr(A_SW, 8'h00); wr(A_SYS, 8'h01);
		$display("test switch done");
	endtask : t_switch

	task automatic t_hot();
		wr(A_SEL, 8'h02); wr(A_MSK, 8'h04); cyc(16); t1 <= 1'b1; cyc(3);
		`CHK("hot irq", 1'b1, irq) `CHK("no kill", 1'b1, hg[0])
		wr(A_SYS, 8'h03); cyc(3); `CHK("hot kill", 1'b0, hg[0])
		wr(A_IRQ, 8'h04); rd(A_IRQ); `CHK("hot held", 32'h4, rdv)
		t1 <= 1'b0; wr(A_IRQ, 8'h04); `CHK("irq clr", 1'b0, irq)
		cyc(16); `CHK("hot reen", 1'b1, hg[0])
		wr(A_MSK, 8'h00); t1 <= 1'b1; cyc(3); `CHK("irq mask", 1'b0, irq)
		t1 <= 1'b0; wr(A_SYS, 8'h01); wr(A_IRQ, 8'h04); t2 <= 1'b1; cyc(3);
		`CHK("second kill", 2'b00, {hg[0], aux})
		t2 <= 1'b0; wr(A_SEL, 8'h00);
		$display("test hot done");
	endtask : t_hot

	task automatic t_supply();
		wr(A_SEL, 8'h02); cyc(16); lvh <= 1'b1; cyc(1); lvh <= 1'b0; cyc(3);
		`CHK("supply kill", 1'b0, hg[0])
		hvh <= 1'b1; wr(A_IRQ, 8'h03); rd(A_IRQ);
		`CHK("supply held", 32'h2, rdv)
		hvh <= 1'b0; wr(A_IRQ, 8'h03); cyc(16);
		`CHK("sup reen", 1'b1, hg[0])
		wr(A_SYS, 8'h09); hvh <= 1'b1; cyc(4);
		`CHK("vis keeps", 1'b1, hg[0])
		hvh <= 1'b0; wr(A_IRQ, 8'h03);
		$display("test supply done");
	endtask : t_supply

	// mid-run reset clears selects, flags and gates
	task automatic t_reset();
		t1 <= 1'b1; cyc(3);
		aresetn <= 1'b0; t1 <= 1'b0; cyc(20);
		aresetn <= 1'b1; cyc(1);
		rd(A_SEL); `CHK("sel reset", 32'h0, rdv)
		rd(A_IRQ); `CHK("hot reset", 32'h0, rdv)
		`CHK("gates reset", 12'h0, {hg, lg, sg, aux})
		$display("test reset done");
	endtask : t_reset

	// ==========================================================
	// main sequence: inputs settle at time zero, reset 20 cycles
	initial begin
		checks = 0; n_mismatch = 0; aresetn = 1'b0;
		awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
		rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
		pwm = 1'b0; t1 = 1'b0; t2 = 1'b0; lvh = 1'b0; hvh = 1'b0;
		sh = 4'h0; sl = 4'h0; ss = 3'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_modes();
		t_bridge_oc();
		t_switch();
		t_hot();
		t_supply();
		t_reset();
		results();
	end
endmodule : hbc_top_tb_top
`default_nettype wire
